// >>> core/ccl_map.vh
// register offsets, field positions and codes for the coprocessor conditional unit
`ifndef CCL_MAP_VH
`define CCL_MAP_VH

// apb byte offsets
`define CCL_CTRL_OFS      8'h00
`define CCL_STATUS_OFS    8'h04
`define CCL_IRQ_EN_OFS    8'h08
`define CCL_IRQ_CLR_OFS   8'h0C
`define CCL_SCAN_OFS      8'h10
`define CCL_STATE_OFS     8'h14
`define CCL_TARGET_OFS    8'h18
`define CCL_DREG_OFS      8'h20

// control register fields
`define CCL_CTRL_EN_BIT   0
`define CCL_CTRL_EXT_LSB  4
`define CCL_CTRL_EXT_MSB  7
`define CCL_CTRL_RST      32'h0000_0001

// interrupt status bits
`define CCL_EV_DONE       0
`define CCL_EV_TRAP       1
`define CCL_EV_VIOL       2
`define CCL_EV_ILLEGAL    3
`define CCL_EV_NUM        4

// operation word fields
`define CCL_LINE_F        4'hF
`define CCL_PAT_LOOP      6'h09
`define CCL_PAT_TRAP      6'h0F
`define CCL_TRAP_ONE      3'h2
`define CCL_TRAP_TWO      3'h3
`define CCL_TRAP_NONE     3'h4

// response word fields
`define CCL_RSP_CA_BIT    15
`define CCL_RSP_FN_MSB    12
`define CCL_RSP_FN_LSB    8
`define CCL_RSP_NULL      5'h00
`define CCL_RSP_TF_BIT    0

// interface register select on the coprocessor port
`define CCL_CIR_COND      1'b0
`define CCL_CIR_RESP      1'b1

`endif

// >>> core/ccl_decode.v
// operation word decoder for the conditional coprocessor forms
`timescale 1ns/1ps
`include "ccl_map.vh"

module ccl_decode (
   // operation word
   input  wire [15:0] op_word,
   // decoded fields
   output wire        is_loop,
   output wire        is_trap,
   output wire [2:0]  coprocessor_select_field,
   output wire [2:0]  counter_sel,
   output reg  [1:0]  operand_words,
   output wire        bad_opmode
);

   wire line_f;

   assign line_f                   = op_word[15:12] == `CCL_LINE_F;
   assign is_loop                  = line_f && (op_word[8:3] == `CCL_PAT_LOOP);
   assign is_trap                  = line_f && (op_word[8:3] == `CCL_PAT_TRAP);
   assign coprocessor_select_field = op_word[11:9];
   assign counter_sel              = op_word[2:0];

   // ----------------------------------------
   // trap operand count
   // ----------------------------------------
   always @* begin
      case (op_word[2:0])
         `CCL_TRAP_ONE:  operand_words = 2'd1;
         `CCL_TRAP_TWO:  operand_words = 2'd2;
         default:        operand_words = 2'd0;
      endcase
   end

   assign bad_opmode = is_trap && (op_word[2:0] != `CCL_TRAP_ONE) &&
                       (op_word[2:0] != `CCL_TRAP_TWO) && (op_word[2:0] != `CCL_TRAP_NONE);

endmodule

// >>> core/ccl_irq.v
// sticky event status, enable and clear with one level interrupt
`timescale 1ns/1ps

module ccl_irq #(
   parameter N = 4
) (
   // clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // events and software access
   input  wire [N-1:0] event_pulse,
   input  wire [N-1:0] clear_mask,
   input  wire         clear_wr,
   input  wire [N-1:0] enable_mask,
   // state
   output wire [N-1:0] status,
   output reg          irq
);

   reg [N-1:0] sticky;

   // ----------------------------------------
   // per bit sticky flags, set wins over clear
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_bit
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sticky[i] <= 1'b0;
            end else if (event_pulse[i]) begin
               sticky[i] <= 1'b1;
            end else if (clear_wr && clear_mask[i]) begin
               sticky[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign status = sticky;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((sticky | event_pulse) & ~(clear_wr ? clear_mask & ~event_pulse : {N{1'b0}}))
                  & enable_mask);
      end
   end

endmodule

// >>> core/ccl_ctl.v
// conditional coprocessor instruction engine with apb register access
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "ccl_map.vh"

// What this block does
// - loop form matched by 001001 in operation bits 8..3; bits 11..9 pick coprocessor.
// - loop form uses operation bits 2..0 to pick the counter data register.
// - condition selector is bits 5..0 of second word; upper bits should be zero.
// - loop form writes the whole second word to the condition interface register.
// - coprocessor-defined extension words follow the selector word and are skipped.
// - last loop word is a signed 16-bit displacement, sign-extended to 32 bits.
// - after selector write, read response and serve primitives until an indicator arrives.
// - on false, loop form decrements only the low 16 bits of the counter.
// - after decrement, fall through if counter word is -1, else branch.
// - branch target is displacement plus scan pointer at the displacement word.
// - trap form matched by 001111 in operation bits 8..3.
// - trap opmode 010 one operand, 011 two, 100 none; others invalid.
// - trap operand words follow extensions and are skipped unused.
// - trap form starts trap exception on true, falls through on false.
// - trap form names its coprocessor in operation bits 11..9.
// - repeatable primitives lacking come-again raise a protocol violation.
module ccl_ctl (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // instruction stream
   input  wire        ins_valid,
   input  wire [15:0] ins_word,
   output reg         ins_ready,
   // coprocessor port
   output reg         cp_wr,
   output reg         cp_rd,
   output reg         cp_sel,
   output reg  [2:0]  cp_id,
   output reg  [15:0] cp_wdata,
   input  wire        cp_ack,
   input  wire [15:0] cp_rdata,
   // primitive service
   output reg         svc_req,
   output reg  [15:0] svc_word,
   input  wire        svc_done,
   // results
   output reg         done,
   output reg         branch_taken,
   output reg         trap_req,
   output reg         proto_viol,
   output reg  [31:0] instruction_scan_pointer,
   output wire        irq
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam [3:0] S_OP   = 4'd0;
   localparam [3:0] S_SEL  = 4'd1;
   localparam [3:0] S_CWR  = 4'd2;
   localparam [3:0] S_RRD  = 4'd3;
   localparam [3:0] S_SVC  = 4'd4;
   localparam [3:0] S_EXT  = 4'd5;
   localparam [3:0] S_DISP = 4'd6;
   localparam [3:0] S_OPND = 4'd7;
   localparam [3:0] S_FIN  = 4'd8;

   // ----------------------------------------
   // storage
   // ----------------------------------------
   reg  [31:0] ctrl;
   reg  [3:0]  irq_en;
   reg  [31:0] target;
   reg  [31:0] dreg [0:7];
   reg  [3:0]  state;
   reg  [15:0] op_word;
   reg  [3:0]  ext_left;
   reg  [1:0]  opnd_left;
   reg  [2:0]  cnt_idx;
   reg         cond_true;
   reg         have_tf;
   reg         is_trap_q;
   reg  [3:0]  ev;

   wire        acc;
   wire        wr_en;
   wire        rd_en;
   wire        hit_dreg;
   wire [2:0]  dreg_idx;
   wire        dec_loop;
   wire        dec_trap;
   wire [2:0]  dec_coprocessor_select_field;
   wire [2:0]  dec_cnt;
   wire [1:0]  dec_opnd;
   wire        dec_bad;
   wire [3:0]  irq_status;
   wire        take;
   wire [15:0] cnt_dec;
   wire [31:0] disp_ext;
   wire [4:0]  rsp_fn;
   wire        rsp_ca;

   // ----------------------------------------
   // decode and interrupt helpers
   // ----------------------------------------
   ccl_decode u_dec (
      .op_word                  (ins_word),
      .is_loop                  (dec_loop),
      .is_trap                  (dec_trap),
      .coprocessor_select_field (dec_coprocessor_select_field),
      .counter_sel              (dec_cnt),
      .operand_words            (dec_opnd),
      .bad_opmode               (dec_bad)
   );

   ccl_irq #(
      .N (`CCL_EV_NUM)
   ) u_irq (
      .pclk        (pclk),
      .presetn     (presetn),
      .event_pulse (ev),
      .clear_mask  (pwdata[3:0]),
      .clear_wr    (wr_en && paddr == `CCL_IRQ_CLR_OFS),
      .enable_mask (irq_en),
      .status      (irq_status),
      .irq         (irq)
   );

   // ----------------------------------------
   // apb access
   // ----------------------------------------
   assign acc      = psel && penable && pready;
   assign wr_en    = acc && pwrite;
   assign rd_en    = psel && penable && !pready && !pwrite;
   assign hit_dreg = paddr[7:5] == 3'h1 && paddr[1:0] == 2'h0;
   assign dreg_idx = paddr[4:2];

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= 1'b0;
         if (psel && penable && !pready) begin
            prdata <= 32'h0000_0000;
            if (hit_dreg) begin
               if (rd_en) prdata <= dreg[dreg_idx];
            end else begin
               case (paddr)
                  `CCL_CTRL_OFS:    if (rd_en) prdata <= ctrl;
                  `CCL_STATUS_OFS:  if (rd_en) prdata <= {28'h000_0000, irq_status};
                  `CCL_IRQ_EN_OFS:  if (rd_en) prdata <= {28'h000_0000, irq_en};
                  `CCL_IRQ_CLR_OFS: prdata <= 32'h0000_0000;
                  `CCL_SCAN_OFS:    if (rd_en) prdata <= instruction_scan_pointer;
                  `CCL_STATE_OFS:   if (rd_en) prdata <= {22'h00_0000, is_trap_q, cond_true, have_tf,
                                                          op_word[11:9], state};
                  `CCL_TARGET_OFS:  if (rd_en) prdata <= target;
                  default:          pslverr <= 1'b1;
               endcase
            end
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl   <= `CCL_CTRL_RST;
         irq_en <= 4'h0;
      end else if (wr_en) begin
         if (paddr == `CCL_CTRL_OFS) ctrl <= pwdata;
         if (paddr == `CCL_IRQ_EN_OFS) irq_en <= pwdata[3:0];
      end
   end

   // ----------------------------------------
   // instruction sequencing
   // ----------------------------------------
   assign take     = ins_valid && ins_ready;
   assign cnt_dec  = dreg[cnt_idx][15:0] - 16'h0001;
   assign disp_ext = {{16{ins_word[15]}}, ins_word};
   assign rsp_fn   = cp_rdata[`CCL_RSP_FN_MSB:`CCL_RSP_FN_LSB];
   assign rsp_ca   = cp_rdata[`CCL_RSP_CA_BIT];

   integer k;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (k = 0; k < 8; k = k + 1) begin
            dreg[k] <= 32'h0000_0000;
         end
      end else if (state == S_DISP && take && !cond_true) begin
         dreg[cnt_idx][15:0] <= cnt_dec;
      end else if (wr_en && hit_dreg) begin
         dreg[dreg_idx] <= pwdata;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state                    <= S_OP;
         op_word                  <= 16'h0000;
         ext_left                 <= 4'h0;
         opnd_left                <= 2'd0;
         cnt_idx                  <= 3'h0;
         cond_true                <= 1'b0;
         have_tf                  <= 1'b0;
         is_trap_q                <= 1'b0;
         ins_ready                <= 1'b0;
         cp_wr                    <= 1'b0;
         cp_rd                    <= 1'b0;
         cp_sel                   <= `CCL_CIR_COND;
         cp_id                    <= 3'h0;
         cp_wdata                 <= 16'h0000;
         svc_req                  <= 1'b0;
         svc_word                 <= 16'h0000;
         done                     <= 1'b0;
         branch_taken             <= 1'b0;
         trap_req                 <= 1'b0;
         proto_viol               <= 1'b0;
         instruction_scan_pointer <= 32'h0000_0000;
         target                   <= 32'h0000_0000;
         ev                       <= 4'h0;
      end else begin
         done         <= 1'b0;
         branch_taken <= 1'b0;
         trap_req     <= 1'b0;
         proto_viol   <= 1'b0;
         ev           <= 4'h0;
         if (wr_en && paddr == `CCL_SCAN_OFS && state == S_OP) begin
            instruction_scan_pointer <= pwdata;
         end else if (take) begin
            instruction_scan_pointer <= instruction_scan_pointer + 32'h0000_0002;
         end
         case (state)
            S_OP: begin
               ins_ready <= ctrl[`CCL_CTRL_EN_BIT];
               if (take) begin
                  op_word   <= ins_word;
                  is_trap_q <= dec_trap;
                  cp_id     <= dec_coprocessor_select_field;
                  opnd_left <= dec_opnd;
                  cnt_idx   <= dec_cnt;
                  have_tf   <= 1'b0;
                  if ((dec_loop || dec_trap) && !dec_bad) begin
                     state <= S_SEL;
                  end else begin
                     ins_ready              <= 1'b0;
                     ev[`CCL_EV_ILLEGAL]    <= 1'b1;
                     state                  <= S_FIN;
                  end
               end
            end
            S_SEL: begin
               if (take) begin
                  ins_ready <= 1'b0;
                  cp_sel    <= `CCL_CIR_COND;
                  cp_wdata  <= ins_word;
                  cp_wr     <= 1'b1;
                  state     <= S_CWR;
               end
            end
            S_CWR: begin
               if (cp_ack) begin
                  cp_wr  <= 1'b0;
                  cp_sel <= `CCL_CIR_RESP;
                  cp_rd  <= 1'b1;
                  state  <= S_RRD;
               end
            end
            S_RRD: begin
               if (cp_ack) begin
                  cp_rd <= 1'b0;
                  if (rsp_fn == `CCL_RSP_NULL && !rsp_ca) begin
                     cond_true <= cp_rdata[`CCL_RSP_TF_BIT];
                     have_tf   <= 1'b1;
                     ext_left  <= ctrl[`CCL_CTRL_EXT_MSB:`CCL_CTRL_EXT_LSB];
                     ins_ready <= 1'b0;
                     state     <= S_EXT;
                  end else if (rsp_fn == `CCL_RSP_NULL) begin
                     cp_rd <= 1'b1;
                  end else if (!rsp_ca) begin
                     proto_viol          <= 1'b1;
                     ev[`CCL_EV_VIOL]    <= 1'b1;
                     state               <= S_FIN;
                  end else begin
                     svc_req  <= 1'b1;
                     svc_word <= cp_rdata;
                     state    <= S_SVC;
                  end
               end
            end
            S_SVC: begin
               if (svc_done) begin
                  svc_req <= 1'b0;
                  cp_rd   <= 1'b1;
                  state   <= S_RRD;
               end
            end
            S_EXT: begin
               // stream shut while leaving, so no word is swallowed here
               if (ext_left == 4'h0) begin
                  if (is_trap_q && opnd_left == 2'd0) begin
                     ins_ready <= 1'b0;
                     state     <= S_FIN;
                  end else begin
                     ins_ready <= 1'b1;
                     state     <= is_trap_q ? S_OPND : S_DISP;
                  end
               end else if (take) begin
                  ext_left <= ext_left - 4'h1;
                  if (ext_left == 4'h1) ins_ready <= 1'b0;
               end else begin
                  ins_ready <= 1'b1;
               end
            end
            S_DISP: begin
               if (take) begin
                  ins_ready <= 1'b0;
                  target    <= instruction_scan_pointer + disp_ext;
                  if (!cond_true && cnt_dec != 16'hFFFF) begin
                     branch_taken             <= 1'b1;
                     instruction_scan_pointer <= instruction_scan_pointer + disp_ext;
                  end
                  state <= S_FIN;
               end
            end
            S_OPND: begin
               if (take) begin
                  opnd_left <= opnd_left - 2'd1;
                  if (opnd_left == 2'd1) begin
                     ins_ready <= 1'b0;
                     state     <= S_FIN;
                  end
               end
            end
            S_FIN: begin
               done             <= 1'b1;
               ev[`CCL_EV_DONE] <= 1'b1;
               if (is_trap_q && have_tf && cond_true) begin
                  trap_req         <= 1'b1;
                  ev[`CCL_EV_TRAP] <= 1'b1;
               end
               cp_sel    <= `CCL_CIR_COND;
               ins_ready <= ctrl[`CCL_CTRL_EN_BIT];
               state     <= S_OP;
            end
            default: begin
               state <= S_OP;
            end
         endcase
      end
   end

endmodule

// >>> verif/ccl_ctl_properties.sv
// port assertions for the conditional coprocessor engine
`timescale 1ns/1ps
module ccl_ctl_properties (
   // clock and reset
   input wire        pclk,
   input wire        presetn,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pready,
   // engine
   input wire        ins_ready,
   input wire        cp_wr,
   input wire        cp_rd,
   input wire [15:0] cp_wdata,
   input wire        cp_ack,
   input wire [15:0] cp_rdata,
   input wire        svc_req,
   input wire        svc_done,
   input wire        done,
   input wire        branch_taken,
   input wire        trap_req,
   input wire        proto_viol
);
   //------------------------------
   // sequences and checks
   //------------------------------
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_cp_req; cp_wr || cp_rd; endsequence
   sequence s_wr_acked; cp_wr && cp_ack; endsequence
   sequence s_bad_prim; cp_rd && cp_ack && cp_rdata[12:8] != 5'h00 && !cp_rdata[15]; endsequence
   chk_apb_answer: assert property (psel && penable && !pready |=> pready)
      else $error("apb answer late");
   chk_cp_hold: assert property (cp_wr && !cp_ack |=> cp_wr && $stable(cp_wdata))
      else $error("condition write dropped");
   chk_write_release: assert property (s_wr_acked |=> !cp_wr)
      else $error("condition write held after ack");
   chk_read_after: assert property (s_wr_acked |-> ##[1:2] cp_rd)
      else $error("response read missing");
   chk_stream_stop: assert property (s_cp_req |-> !ins_ready)
      else $error("stream open in dialogue");
   chk_svc_hold: assert property (svc_req && !svc_done |=> svc_req)
      else $error("service request dropped");
   chk_viol_flag: assert property (s_bad_prim |-> ##[1:3] proto_viol)
      else $error("violation not flagged");
   chk_trap_done: assert property (trap_req |-> done && !branch_taken)
      else $error("trap without finish");
   chk_branch_done: assert property (branch_taken |=> done)
      else $error("branch without finish");
endmodule

bind ccl_ctl ccl_ctl_properties chk_u (.pclk, .presetn, .psel, .penable, .pready, .ins_ready, .cp_wr, .cp_rd,
   .cp_wdata, .cp_ack, .cp_rdata, .svc_req, .svc_done, .done, .branch_taken, .trap_req, .proto_viol);

// >>> verif/ccl_cp_model.sv
// coprocessor model answering the condition and response registers
`timescale 1ns/1ps
module ccl_cp_model (
   // clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // coprocessor port
   input  wire         cp_wr,
   input  wire         cp_rd,
   input  wire         cp_sel,
   input  wire  [2:0]  cp_id,
   input  wire  [15:0] cp_wdata,
   output logic        cp_ack,
   output logic [15:0] cp_rdata,
   // primitive service
   input  wire         svc_req,
   output logic        svc_done
);
   logic [15:0] rsp [0:3];
   logic [15:0] wr_word;
   logic [2:0]  wr_id;
   logic        wr_sel;
   int          rsp_i;
   int          n_wr;
   int          lat;
   int          cnt;
   //------------------------------
   // one answer per request after lat cycles
   //------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cp_ack <= 1'b0;
         cp_rdata <= 16'h5A5A;
         svc_done <= 1'b0;
         cnt <= 0;
      end else begin
         cp_ack <= 1'b0;
         cp_rdata <= ~cp_rdata;
         svc_done <= svc_req && !svc_done;
         if ((cp_wr || cp_rd) && !cp_ack) begin
            cnt <= cnt + 1;
            if (cnt >= lat) begin
               cnt <= 0;
               cp_ack <= 1'b1;
               if (cp_wr) begin
                  wr_word <= cp_wdata;
                  wr_id <= cp_id;
                  wr_sel <= cp_sel;
                  n_wr <= n_wr + 1;
               end else begin
                  cp_rdata <= rsp[rsp_i];
                  rsp_i <= rsp_i + 1;
               end
            end
         end
      end
   end
endmodule

// >>> verif/ccl_ctl_tb_top.sv
// self-checking bench for the conditional coprocessor engine
`timescale 1ns/1ps
`include "ccl_map.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
   $display("Error %0t: got %0h want %0h", $time, a, b); end end
module ccl_ctl_tb_top;
   typedef struct {logic [15:0] op; logic [15:0] rsp; logic [31:0] init; int tail;
                   logic [31:0] cnt; int br; int trap;} ccl_row_t;
   localparam logic [15:0] disp_word = 16'hFFF0;
   localparam logic [31:0] ptr0      = 32'h0000_0100;
   logic        pclk = 1'b0;
   logic        presetn;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        ins_valid = 1'b0;
   logic [15:0] ins_word = 16'h0;
   logic [31:0] prdata, instruction_scan_pointer, q, exp_ptr;
   logic [15:0] cp_wdata, cp_rdata, svc_word, svc_seen;
   logic [2:0]  cp_id;
   logic        pready, pslverr, ins_ready, cp_wr, cp_rd, cp_sel, cp_ack, svc_req, svc_done;
   logic        done, branch_taken, trap_req, proto_viol, irq, e;
   int          err_count, total_checks, n_ev, n_br, n_trap, n_viol, b0, t0, w0;
   ccl_row_t    r;
   ccl_row_t    rows [6] = '{
      '{16'hF24B, 16'h0000, 32'h1234_0005, 1, 32'h1234_0004, 1, 0},
      '{16'hF448, 16'h0000, 32'hABCD_0000, 1, 32'hABCD_FFFF, 0, 0},
      '{16'hF04F, 16'h0001, 32'h0000_0009, 1, 32'h0000_0009, 0, 0},
      '{16'hF67C, 16'h0001, 32'h0000_0000, 0, 32'h0000_0000, 0, 1},
      '{16'hF07A, 16'h0000, 32'h0000_0000, 1, 32'h0000_0000, 0, 0},
      '{16'hF07B, 16'h0001, 32'h0000_0000, 2, 32'h0000_0000, 0, 1}};
   logic [15:0] bad_ops [6] = '{16'hF078, 16'hF079, 16'hF07D, 16'hF07E, 16'hF07F, 16'hF240};

   ccl_ctl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .ins_valid, .ins_word, .ins_ready, .cp_wr, .cp_rd, .cp_sel, .cp_id, .cp_wdata, .cp_ack, .cp_rdata,
      .svc_req, .svc_word, .svc_done, .done, .branch_taken, .trap_req, .proto_viol, .instruction_scan_pointer, .irq);
   ccl_cp_model cpm (.pclk, .presetn, .cp_wr, .cp_rd, .cp_sel, .cp_id, .cp_wdata, .cp_ack, .cp_rdata,
      .svc_req, .svc_done);

   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      if (done || proto_viol) n_ev <= n_ev + 1;
      if (branch_taken) n_br <= n_br + 1;
      if (trap_req) n_trap <= n_trap + 1;
      if (proto_viol) n_viol <= n_viol + 1;
      if (svc_req) svc_seen <= svc_word;
   end

   //------------------------------
   // tasks
   //------------------------------
   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic hang;
      err_count++;
      $display("Error %0t: wait ran out", $time);
      test_done();
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) hang();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK(q, x)
   endtask
   task automatic send_word(input logic [15:0] w);
      int n;
      ins_valid <= 1'b1;
      ins_word <= w;
      n = 0;
      do begin @(negedge pclk); n++; end while (ins_ready !== 1'b1 && n < 200);
      if (ins_ready !== 1'b1) hang();
      @(posedge pclk);
   endtask
   task automatic instr(input logic [15:0] op, input logic [15:0] sel, input int nw);
      int b, n;
      b = n_ev;
      send_word(op);
      if (nw >= 0) send_word(sel);
      for (int k = 0; k < nw; k++) send_word(disp_word);
      ins_valid <= 1'b0;
      n = 0;
      while (n_ev == b && n < 300) begin @(posedge pclk); n++; end
      if (n_ev == b) hang();
      repeat (2) @(posedge pclk);
   endtask
   task automatic irq_chk(input logic x);
      repeat (2) @(negedge pclk);
      `CHK(irq, x)
      @(posedge pclk);
   endtask

   initial begin
      presetn = 1'b0;
      cpm.lat = 0;
      cpm.rsp_i = 0;
      cpm.n_wr = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(`CCL_CTRL_OFS, `CCL_CTRL_RST);
      rd_chk(`CCL_IRQ_EN_OFS, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      `CHK(e, 1'b1)
      for (int i = 0; i < 6; i++) begin
         r = rows[i];
         apb(1'b1, `CCL_SCAN_OFS, ptr0);
         apb(1'b1, `CCL_DREG_OFS + {3'h0, r.op[2:0], 2'h0}, r.init);
         cpm.rsp[0] = r.rsp;
         cpm.rsp_i = 0;
         b0 = n_br;
         t0 = n_trap;
         instr(r.op, 16'h0010 + 16'(i), r.tail);
         exp_ptr = ptr0 + 32'h4 + 32'(2 * r.tail);
         if (r.br) exp_ptr = ptr0 + 32'h4 + {{16{disp_word[15]}}, disp_word};
         `CHK(instruction_scan_pointer, exp_ptr)
         `CHK(n_br - b0, r.br)
         `CHK(n_trap - t0, r.trap)
         `CHK(cpm.wr_word, 16'h0010 + 16'(i))
         `CHK(cpm.wr_sel, `CCL_CIR_COND)
         `CHK(cpm.wr_id, r.op[11:9])
         rd_chk(`CCL_DREG_OFS + {3'h0, r.op[2:0], 2'h0}, r.cnt);
      end
      // two extension words, slow coprocessor asking for a service
      apb(1'b1, `CCL_CTRL_OFS, 32'h0000_0021);
      apb(1'b1, `CCL_SCAN_OFS, ptr0);
      apb(1'b1, `CCL_DREG_OFS + 8'h04, 32'h0000_0001);
      cpm.lat = 3;
      cpm.rsp = '{16'h8100, 16'h8000, 16'h0000, 16'h0000};
      cpm.rsp_i = 0;
      instr(16'hF249, 16'h0003, 3);
      `CHK(cpm.rsp_i, 3)
      `CHK(svc_seen, 16'h8100)
      `CHK(instruction_scan_pointer, ptr0 + 32'h8 + {{16{disp_word[15]}}, disp_word})
      rd_chk(`CCL_DREG_OFS + 8'h04, 32'h0);
      apb(1'b1, `CCL_CTRL_OFS, `CCL_CTRL_RST);
      cpm.lat = 0;
      // repeatable primitive without come-again, then interrupt handling
      apb(1'b1, `CCL_IRQ_CLR_OFS, 32'h0000_000F);
      apb(1'b1, `CCL_IRQ_EN_OFS, 32'h0000_0004);
      cpm.rsp[0] = 16'h0100;
      cpm.rsp_i = 0;
      w0 = n_viol;
      instr(16'hF249, 16'h0005, 0);
      `CHK(n_viol - w0, 1)
      irq_chk(1'b1);
      apb(1'b1, `CCL_IRQ_EN_OFS, 32'h0);
      irq_chk(1'b0);
      apb(1'b1, `CCL_IRQ_EN_OFS, 32'h0000_0004);
      irq_chk(1'b1);
      apb(1'b1, `CCL_IRQ_CLR_OFS, 32'h0000_000F);
      irq_chk(1'b0);
      rd_chk(`CCL_STATUS_OFS, 32'h0);
      // invalid trap codes and a non-matching pattern
      foreach (bad_ops[k]) begin
         apb(1'b1, `CCL_IRQ_CLR_OFS, 32'h0000_000F);
         w0 = cpm.n_wr;
         instr(bad_ops[k], 16'h0, -1);
         `CHK(cpm.n_wr, w0)
         rd_chk(`CCL_STATUS_OFS, 32'h0000_0009);
      end
      test_done();
   end
endmodule
